// >>> rtl/tef_consts.svh
// Summary of operation
// - Events set flags; enabled flags hold requests.
// - Flag clears on read-while-set then zero write.
// - Event between steps keeps flag set.
// - Edge counting: wrap flag at terminal to zero.
// - Center counting: wrap flag at top reversal.
// - Capture edge select: none, rise, fall, both.
// - Output compare flags every counter match.
// - Edge PWM match flags, ends duty.
// - Center PWM flags both matches per period.
// - Counter write clears counter and prescaler.
// - Halted counter reads return live value.
// - Halted status or counter write drops latch.
// - Halted channel reads live; control write drops latch.
// - Capture mode ignores channel value writes.
// - Compare buffer loads at next counter step.
// - PWM buffer loads stepping modulo-1 to modulo.
// - Center value equal modulo gives full duty.
// - Center value modulo-1 gives almost full duty.
// - Zero to nonzero waits for next period.
// - Nonzero to zero finishes period at old duty.
// - Halted status write drops modulo write latch.
// - Edge PWM output frozen while clock off.
// - Interrupt request is active high.
// - Reset clears status control; channels capture.
`ifndef TEF_CONSTS_SVH
`define TEF_CONSTS_SVH
`define TEF_CNT_RST   16'h0000
`define TEF_CNT_MAX   16'hffff
`define TEF_ONE       16'h0001
`define TEF_CLK_OFF   2'h0
`define TEF_PS_RST    7'h00
`define TEF_PS_FULL   7'h7f
`define TEF_PS_TOP    3'h7
`define TEF_EDGE_NONE 2'h0
`define TEF_EDGE_RISE 2'h1
`define TEF_EDGE_FALL 2'h2
`define TEF_EDGE_BOTH 2'h3
`define TEF_BYTE_RST  8'h00
`endif

// >>> rtl/tef_pkg.sv
package tef_pkg;
	// Channel operating modes.
	typedef enum logic [1:0] {
		mode_ic,
		mode_oc,
		mode_edge_aligned_pwm,
		mode_center_aligned_pwm
	} tef_mode_t;
endpackage : tef_pkg

// >>> rtl/tef_pin_sync.sv
`timescale 1ns/1ps
module tef_pin_sync (
	// Clock and reset.
	input  wire logic i_mclk,
	input  wire logic i_sys_rst,
	// Raw pin.
	input  wire logic i_pin,
	// Qualified edge pulses.
	output logic      o_rise,
	output logic      o_fall
);
	import tef_pkg::*;

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;
	wire logic chg = (s2_ff == s3_ff) && (s3_ff != lvl_ff);

	// Three stages; a change counts once the last two agree.
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			s1_ff  <= 1'b0;
			s2_ff  <= 1'b0;
			s3_ff  <= 1'b0;
			lvl_ff <= 1'b0;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end
		else
		begin
			s1_ff  <= i_pin;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= chg ? s3_ff : lvl_ff;
			o_rise <= chg && s3_ff;
			o_fall <= chg && !s3_ff;
		end
	end
endmodule : tef_pin_sync

// >>> rtl/tef_timer.sv
`timescale 1ns/1ps
`include "tef_consts.svh"
module tef_timer (
	// Clock and reset.
	input  wire logic       i_mclk,
	input  wire logic       i_sys_rst,
	// Debug halt and channel pin.
	input  wire logic       i_dbg_halt,
	input  wire logic       i_ch_pin,
	// Timer status-control write and flag access.
	input  wire logic       i_tsc_wr,
	input  wire logic [1:0] i_clk_sel,
	input  wire logic       i_center_sel,
	input  wire logic       i_wrap_ie,
	input  wire logic [2:0] i_presc_sel,
	input  wire logic       i_wrap_flag_rd,
	input  wire logic       i_wrap_bit_zero,
	// Channel status-control write and flag access.
	input  wire logic       i_csc_wr,
	input  wire logic [1:0] i_ch_mode_sel,
	input  wire logic [1:0] i_edge_sel,
	input  wire logic       i_ch_ie,
	input  wire logic       i_ch_flag_rd,
	input  wire logic       i_ch_bit_zero,
	// Byte accesses.
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_cnt_wr,
	input  wire logic       i_cnt_rd_hi,
	input  wire logic       i_cnt_rd_lo,
	input  wire logic       i_mod_wr_hi,
	input  wire logic       i_mod_wr_lo,
	input  wire logic       i_cv_wr_hi,
	input  wire logic       i_cv_wr_lo,
	input  wire logic       i_cv_rd_hi,
	input  wire logic       i_cv_rd_lo,
	// Read data, flags, request and channel pin.
	output logic [7:0]      o_cnt_rdata,
	output logic [7:0]      o_cv_rdata,
	output logic            o_wrap_flag,
	output logic            o_ch_flag,
	output logic            o_irq,
	output logic            o_ch_out,
	output logic            o_ch_oe
);
	import tef_pkg::*;

	// Flag step: an event beats both read and clear.
	function automatic logic [1:0] tef_flag_nxt(input logic flag,
		input logic arm, input logic evt, input logic rd,
		input logic clr);
		logic [1:0] r;
		r = {flag, arm};
		if (evt)
			r = 2'h2;
		else if (rd && flag)
			r = 2'h3;
		else if (clr && arm)
			r = 2'h0;
		tef_flag_nxt = r;
	endfunction : tef_flag_nxt

	logic [1:0]  clk_sel_ff;
	logic        center_ff;
	logic        wrap_ie_ff;
	logic [2:0]  presc_sel_ff;
	logic [1:0]  ms_ff;
	logic [1:0]  els_ff;
	logic        ch_ie_ff;
	logic [6:0]  presc_ff;
	logic [15:0] cnt_ff;
	logic        up_ff;
	logic [15:0] mod_ff;
	logic [7:0]  mod_hi_ff;
	logic        mod_hw_ff;
	logic [15:0] cv_ff;
	logic [15:0] cvb_ff;
	logic        cv_hw_ff;
	logic        cv_lw_ff;
	logic        cnt_lat_ff;
	logic [7:0]  cnt_buf_ff;
	logic        cv_lat_ff;
	logic [7:0]  cv_buf_ff;
	logic        wrap_arm_ff;
	logic        ch_arm_ff;
	logic        zero_ff;
	logic        act_ff;
	logic        rise;
	logic        fall;

	// Mode and timing decode.
	wire tef_mode_t mode = center_ff ? mode_center_aligned_pwm :
		ms_ff[1] ? mode_edge_aligned_pwm : ms_ff[0] ? mode_oc : mode_ic;
	wire logic [6:0]  ps_mask = `TEF_PS_FULL >> (`TEF_PS_TOP - presc_sel_ff);
	wire logic        run = (clk_sel_ff != `TEF_CLK_OFF) && !i_dbg_halt;
	wire logic        tick = run && (presc_ff == ps_mask);
	wire logic [15:0] top = (mod_ff == `TEF_CNT_RST) ? `TEF_CNT_MAX : mod_ff;
	wire logic        at_top = cnt_ff == top;
	wire logic [15:0] inc = cnt_ff + `TEF_ONE;
	wire logic [15:0] dec = cnt_ff - `TEF_ONE;
	wire logic        at_zero = cnt_ff == `TEF_CNT_RST;

	// Counter next value for both counting styles.
	wire logic [15:0] nxt_cnt = !center_ff ? (at_top ? `TEF_CNT_RST : inc) :
		up_ff ? (at_top ? dec : inc) : (at_zero ? inc : dec);
	wire logic nxt_up = !center_ff || (up_ff ? !at_top : at_zero);
	wire logic wrap_evt = tick && at_top && (!center_ff || up_ff);
	wire logic pwm_upd = tick && up_ff && (cnt_ff == top - `TEF_ONE);

	// Channel events.
	wire logic match = tick && (cnt_ff == cv_ff) && (mode != mode_ic);
	wire logic edge_hit = (els_ff == `TEF_EDGE_RISE && rise) ||
		(els_ff == `TEF_EDGE_FALL && fall) ||
		(els_ff == `TEF_EDGE_BOTH && (rise || fall));
	wire logic cap_evt = (mode == mode_ic) && edge_hit;
	wire logic ch_evt = cap_evt || match;

	// Channel value buffer control.
	wire logic cv_ok = mode != mode_ic;
	wire logic cv_both = cv_hw_ff && cv_lw_ff;
	wire logic cv_load = cv_both && ((clk_sel_ff == `TEF_CLK_OFF) ||
		((mode == mode_oc) ? tick : pwm_upd));

	// Flag steps; the write-zero only counts inside a register write.
	wire logic [1:0] nxt_wrap = tef_flag_nxt(o_wrap_flag, wrap_arm_ff,
		wrap_evt, i_wrap_flag_rd, i_tsc_wr && i_wrap_bit_zero);
	wire logic [1:0] nxt_ch = tef_flag_nxt(o_ch_flag, ch_arm_ff, ch_evt,
		i_ch_flag_rd, i_csc_wr && i_ch_bit_zero);

	// Center duty: zero setting only takes effect at a period boundary.
	wire logic zero_now = (wrap_evt && center_ff) ?
		(cv_ff == `TEF_CNT_RST || cv_ff[15]) : zero_ff;
	wire logic cp_act = !zero_now && !cv_ff[15] &&
		((cv_ff >= mod_ff) || (nxt_cnt < cv_ff));
	wire logic oc_act = (els_ff == `TEF_EDGE_RISE) ? !act_ff :
		(els_ff == `TEF_EDGE_BOTH);
	wire logic nxt_act = (mode == mode_ic) ? 1'b0 :
		(mode == mode_oc) ? (match && els_ff != `TEF_EDGE_NONE ? oc_act : act_ff) :
		(mode == mode_edge_aligned_pwm) ? (wrap_evt ? (cv_ff != `TEF_CNT_RST) :
		(match ? 1'b0 : act_ff)) : (tick ? cp_act : act_ff);
	wire logic pwm = (mode == mode_edge_aligned_pwm) || (mode == mode_center_aligned_pwm);
	wire logic nxt_pin = pwm ? (nxt_act ^ els_ff[0]) : nxt_act;
	wire logic pin_upd = (mode != mode_edge_aligned_pwm) || tick;

	tef_pin_sync u_sync (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_pin     (i_ch_pin),
		.o_rise    (rise),
		.o_fall    (fall)
	);

	// Control fields; reset leaves the clock off and channels capturing.
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			clk_sel_ff   <= `TEF_CLK_OFF;
			center_ff    <= 1'b0;
			wrap_ie_ff   <= 1'b0;
			presc_sel_ff <= 3'h0;
			ms_ff        <= 2'h0;
			els_ff       <= `TEF_EDGE_NONE;
			ch_ie_ff     <= 1'b0;
		end
		else
		begin
			if (i_tsc_wr)
			begin
				clk_sel_ff   <= i_clk_sel;
				center_ff    <= i_center_sel;
				wrap_ie_ff   <= i_wrap_ie;
				presc_sel_ff <= i_presc_sel;
			end
			if (i_csc_wr)
			begin
				ms_ff    <= i_ch_mode_sel;
				els_ff   <= i_edge_sel;
				ch_ie_ff <= i_ch_ie;
			end
		end
	end

	// Prescaler and counter; any counter byte write restarts both.
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			presc_ff <= `TEF_PS_RST;
			cnt_ff   <= `TEF_CNT_RST;
			up_ff    <= 1'b1;
		end
		else if (i_cnt_wr)
		begin
			presc_ff <= `TEF_PS_RST;
			cnt_ff   <= `TEF_CNT_RST;
			up_ff    <= 1'b1;
		end
		else if (run)
		begin
			presc_ff <= tick ? `TEF_PS_RST : presc_ff + 7'h01;
			cnt_ff   <= tick ? nxt_cnt : cnt_ff;
			up_ff    <= tick ? nxt_up : up_ff;
		end
	end

	// Modulo byte pair; a status write cancels a half-written value.
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			mod_ff    <= `TEF_CNT_RST;
			mod_hi_ff <= `TEF_BYTE_RST;
			mod_hw_ff <= 1'b0;
		end
		else if (i_tsc_wr)
			mod_hw_ff <= 1'b0;
		else if (i_mod_wr_hi)
		begin
			mod_hi_ff <= i_wdata;
			mod_hw_ff <= 1'b1;
		end
		else if (i_mod_wr_lo && mod_hw_ff)
		begin
			mod_ff    <= {mod_hi_ff, i_wdata};
			mod_hw_ff <= 1'b0;
		end
	end

	// Channel value write buffer.
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cvb_ff   <= `TEF_CNT_RST;
			cv_hw_ff <= 1'b0;
			cv_lw_ff <= 1'b0;
		end
		else if (i_csc_wr || cv_load)
		begin
			cv_hw_ff <= 1'b0;
			cv_lw_ff <= 1'b0;
		end
		else if (cv_ok)
		begin
			if (i_cv_wr_hi)
			begin
				cvb_ff[15:8] <= i_wdata;
				cv_hw_ff     <= 1'b1;
			end
			if (i_cv_wr_lo)
			begin
				cvb_ff[7:0] <= i_wdata;
				cv_lw_ff    <= 1'b1;
			end
		end
	end

	// Channel value: capture takes the counter, otherwise buffer loads.
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cv_ff <= `TEF_CNT_RST;
		else if (cap_evt)
			cv_ff <= cnt_ff;
		else if (cv_load)
			cv_ff <= cvb_ff;
	end

	// Counter reads: high byte latches low byte, except while halted.
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_cnt_rdata <= `TEF_BYTE_RST;
			cnt_buf_ff  <= `TEF_BYTE_RST;
			cnt_lat_ff  <= 1'b0;
		end
		else
		begin
			if (i_cnt_rd_hi)
				o_cnt_rdata <= cnt_ff[15:8];
			else if (i_cnt_rd_lo)
				o_cnt_rdata <= (cnt_lat_ff && !i_dbg_halt) ?
					cnt_buf_ff : cnt_ff[7:0];
			if (i_cnt_wr || (i_dbg_halt && i_tsc_wr))
				cnt_lat_ff <= 1'b0;
			else if (i_cnt_rd_hi && !i_dbg_halt)
			begin
				cnt_lat_ff <= 1'b1;
				cnt_buf_ff <= cnt_ff[7:0];
			end
			else if (i_cnt_rd_lo && !i_dbg_halt)
				cnt_lat_ff <= 1'b0;
		end
	end

	// Channel value reads, same latching scheme.
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_cv_rdata <= `TEF_BYTE_RST;
			cv_buf_ff  <= `TEF_BYTE_RST;
			cv_lat_ff  <= 1'b0;
		end
		else
		begin
			if (i_cv_rd_hi)
				o_cv_rdata <= cv_ff[15:8];
			else if (i_cv_rd_lo)
				o_cv_rdata <= (cv_lat_ff && !i_dbg_halt) ?
					cv_buf_ff : cv_ff[7:0];
			if (i_dbg_halt && i_csc_wr)
				cv_lat_ff <= 1'b0;
			else if (i_cv_rd_hi && !i_dbg_halt)
			begin
				cv_lat_ff <= 1'b1;
				cv_buf_ff <= cv_ff[7:0];
			end
			else if (i_cv_rd_lo && !i_dbg_halt)
				cv_lat_ff <= 1'b0;
		end
	end

	// Flags, request and channel pin; the request is registered.
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			{o_wrap_flag, wrap_arm_ff} <= 2'h0;
			{o_ch_flag, ch_arm_ff}     <= 2'h0;
			o_irq    <= 1'b0;
			zero_ff  <= 1'b1;
			act_ff   <= 1'b0;
			o_ch_out <= 1'b0;
			o_ch_oe  <= 1'b0;
		end
		else
		begin
			{o_wrap_flag, wrap_arm_ff} <= nxt_wrap;
			{o_ch_flag, ch_arm_ff}     <= nxt_ch;
			o_irq <= (o_wrap_flag && wrap_ie_ff) ||
				(o_ch_flag && ch_ie_ff);
			zero_ff <= zero_now;
			act_ff  <= pin_upd ? nxt_act : act_ff;
			o_ch_out <= pin_upd ? nxt_pin : o_ch_out;
			o_ch_oe <= (mode != mode_ic) && (els_ff != `TEF_EDGE_NONE);
		end
	end

	// Checks.
	chk_irq_from_flag: assert property (@(posedge i_mclk)
		disable iff (i_sys_rst) (o_ch_flag && ch_ie_ff) |=> o_irq)
		else $error("request missing for enabled channel flag");
	chk_clear_needs_read: assert property (@(posedge i_mclk)
		disable iff (i_sys_rst)
		(o_wrap_flag && !wrap_arm_ff && i_tsc_wr && i_wrap_bit_zero)
		|=> o_wrap_flag)
		else $error("wrap flag cleared without prior read");
	chk_event_beats_clear: assert property (@(posedge i_mclk)
		disable iff (i_sys_rst) ch_evt |=> (o_ch_flag && !ch_arm_ff))
		else $error("channel event lost or clear still armed");
	chk_wrap_to_zero: assert property (@(posedge i_mclk)
		disable iff (i_sys_rst)
		(tick && !center_ff && at_top && !i_cnt_wr)
		|=> (cnt_ff == `TEF_CNT_RST) && o_wrap_flag)
		else $error("edge counting wrap wrong");
	chk_center_turn: assert property (@(posedge i_mclk)
		disable iff (i_sys_rst)
		(tick && center_ff && up_ff && at_top && !i_cnt_wr)
		|=> !up_ff && o_wrap_flag)
		else $error("center reversal did not flag");
	chk_cnt_clear: assert property (@(posedge i_mclk)
		disable iff (i_sys_rst) i_cnt_wr
		|=> (cnt_ff == `TEF_CNT_RST) && (presc_ff == `TEF_PS_RST))
		else $error("counter write did not clear");
	chk_capture_ignore: assert property (@(posedge i_mclk)
		disable iff (i_sys_rst)
		(mode == mode_ic && (i_cv_wr_hi || i_cv_wr_lo) && !i_csc_wr)
		|=> !cv_hw_ff && !cv_lw_ff)
		else $error("capture mode accepted value write");
	chk_edge_aligned_pwm_frozen: assert property (@(posedge i_mclk)
		disable iff (i_sys_rst)
		(mode == mode_edge_aligned_pwm && clk_sel_ff == `TEF_CLK_OFF) |=> $stable(o_ch_out))
		else $error("edge pwm output moved with clock off");
	chk_halt_live_read: assert property (@(posedge i_mclk)
		disable iff (i_sys_rst) (i_dbg_halt && i_cnt_rd_lo && !i_cnt_rd_hi)
		|=> o_cnt_rdata == $past(cnt_ff[7:0]))
		else $error("halted read returned latched byte");
	chk_capture_flag: assert property (@(posedge i_mclk)
		disable iff (i_sys_rst) cap_evt |=> o_ch_flag ##1 o_irq || !ch_ie_ff)
		else $error("capture edge did not raise flag");
endmodule : tef_timer

// >>> dv/timer_event_flags_and_updates_bench.sv
`timescale 1ns/1ps
module timer_event_flags_and_updates_bench;
	// Clock, reset, debug halt and channel pin.
	logic       i_mclk, i_sys_rst, i_dbg_halt, i_ch_pin;
	// Status-control and channel-control fields and strobes.
	logic       i_tsc_wr, i_center_sel, i_wrap_ie, i_wrap_flag_rd;
	logic       i_wrap_bit_zero, i_csc_wr, i_ch_ie, i_ch_flag_rd;
	logic       i_ch_bit_zero;
	logic [1:0] i_clk_sel, i_ch_mode_sel, i_edge_sel;
	logic [2:0] i_presc_sel;
	// Byte access strobes and data.
	logic [7:0] i_wdata;
	logic       i_cnt_wr, i_cnt_rd_hi, i_cnt_rd_lo, i_mod_wr_hi;
	logic       i_mod_wr_lo, i_cv_wr_hi, i_cv_wr_lo, i_cv_rd_hi, i_cv_rd_lo;
	// Observed outputs.
	logic [7:0] o_cnt_rdata, o_cv_rdata;
	logic       o_wrap_flag, o_ch_flag, o_irq, o_ch_out, o_ch_oe;
	// Bookkeeping.
	int         n_fail = 0;
	int         compares = 0;
	logic [15:0] v, w;
	logic [15:0] duty_val [4] = '{16'h0004, 16'h0003, 16'h0000, 16'h0002};
	int         duty_lo [4] = '{32, 20, 0, 8};
	int         duty_hi [4] = '{32, 31, 0, 16};
	int         h;
	logic       exp;

	tef_timer uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
		.i_dbg_halt(i_dbg_halt), .i_ch_pin(i_ch_pin), .i_tsc_wr(i_tsc_wr),
		.i_clk_sel(i_clk_sel), .i_center_sel(i_center_sel),
		.i_wrap_ie(i_wrap_ie), .i_presc_sel(i_presc_sel),
		.i_wrap_flag_rd(i_wrap_flag_rd), .i_wrap_bit_zero(i_wrap_bit_zero),
		.i_csc_wr(i_csc_wr), .i_ch_mode_sel(i_ch_mode_sel),
		.i_edge_sel(i_edge_sel), .i_ch_ie(i_ch_ie),
		.i_ch_flag_rd(i_ch_flag_rd), .i_ch_bit_zero(i_ch_bit_zero),
		.i_wdata(i_wdata), .i_cnt_wr(i_cnt_wr), .i_cnt_rd_hi(i_cnt_rd_hi),
		.i_cnt_rd_lo(i_cnt_rd_lo), .i_mod_wr_hi(i_mod_wr_hi),
		.i_mod_wr_lo(i_mod_wr_lo), .i_cv_wr_hi(i_cv_wr_hi),
		.i_cv_wr_lo(i_cv_wr_lo), .i_cv_rd_hi(i_cv_rd_hi),
		.i_cv_rd_lo(i_cv_rd_lo), .o_cnt_rdata(o_cnt_rdata),
		.o_cv_rdata(o_cv_rdata), .o_wrap_flag(o_wrap_flag),
		.o_ch_flag(o_ch_flag), .o_irq(o_irq), .o_ch_out(o_ch_out),
		.o_ch_oe(o_ch_oe));

	// Bus clock at 10 MHz.
	initial
	begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end

	// Inputs move 1 ns after the edge so sampling never races.
	task automatic tick(input int n = 1);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : tick

	task automatic check(input logic [15:0] seen, input logic [15:0] want,
		input string what);
		compares++;
		if (seen !== want)
		begin
			n_fail++;
			$display("[FAIL] %0t ns: %s seen %h want %h", $time, what, seen,
				want);
		end
	endtask : check

	task automatic end_test(input string name);
		$display("test %s finished, %0d failures so far", name, n_fail);
	endtask : end_test

	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// Status-control write; config fields are held on the ports.
	task automatic tsc(input logic zero);
		i_wrap_bit_zero = zero;
		i_tsc_wr = 1'b1;
		tick();
		i_tsc_wr = 1'b0;
		i_wrap_bit_zero = 1'b0;
	endtask : tsc

	task automatic csc(input logic zero);
		i_ch_bit_zero = zero;
		i_csc_wr = 1'b1;
		tick();
		i_csc_wr = 1'b0;
		i_ch_bit_zero = 1'b0;
	endtask : csc

	// Two-step clear; halting freezes the counter so no event sneaks in.
	task automatic clr(input logic ch, input logic hold);
		if (hold)
			i_dbg_halt = 1'b1;
		{i_ch_flag_rd, i_wrap_flag_rd} = {ch, !ch};
		tick();
		{i_ch_flag_rd, i_wrap_flag_rd} = 2'h0;
		if (ch)
			csc(1'b1);
		else
			tsc(1'b1);
		if (hold)
			i_dbg_halt = 1'b0;
		tick(2);
	endtask : clr

	// Sixteen-bit write, high byte first: channel value or modulo.
	task automatic wr16(input logic cv, input logic [15:0] val);
		i_wdata = val[15:8];
		{i_cv_wr_hi, i_mod_wr_hi} = {cv, !cv};
		tick();
		{i_cv_wr_hi, i_mod_wr_hi} = 2'h0;
		{i_cv_wr_lo, i_mod_wr_lo} = {cv, !cv};
		i_wdata = val[7:0];
		tick();
		{i_cv_wr_lo, i_mod_wr_lo} = 2'h0;
	endtask : wr16

	// Sixteen-bit read of channel value or counter, data one cycle later.
	task automatic rd16(input logic cv, output logic [15:0] val);
		{i_cv_rd_hi, i_cnt_rd_hi} = {cv, !cv};
		tick();
		{i_cv_rd_hi, i_cnt_rd_hi} = 2'h0;
		{i_cv_rd_lo, i_cnt_rd_lo} = {cv, !cv};
		val[15:8] = cv ? o_cv_rdata : o_cnt_rdata;
		tick();
		{i_cv_rd_lo, i_cnt_rd_lo} = 2'h0;
		val[7:0] = cv ? o_cv_rdata : o_cnt_rdata;
	endtask : rd16

	task automatic cnt_clr;
		i_cnt_wr = 1'b1;
		tick();
		i_cnt_wr = 1'b0;
	endtask : cnt_clr

	// Bounded wait for a flag to rise, then a compare on it.
	task automatic wait_set(input logic ch, input int lim, input string what);
		int k;
		k = 0;
		while (((ch ? o_ch_flag : o_wrap_flag) !== 1'b1) && k < lim)
		begin
			tick();
			k++;
		end
		check({15'h0, ch ? o_ch_flag : o_wrap_flag}, 16'h0001, what);
	endtask : wait_set

	task automatic count_high(input int n, output int hi);
		hi = 0;
		repeat (n)
		begin
			tick();
			if (o_ch_out === 1'b1)
				hi++;
		end
	endtask : count_high

	// A hang is cut short well beyond the expected few hundred cycles.
	initial
	begin
		#2000000;
		n_fail++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		test_done();
	end

	// Main sequence.
	initial
	begin
		i_sys_rst = 1'b1;
		{i_dbg_halt, i_ch_pin, i_tsc_wr, i_center_sel, i_wrap_ie} = '0;
		{i_wrap_flag_rd, i_wrap_bit_zero, i_csc_wr, i_ch_ie} = '0;
		{i_ch_flag_rd, i_ch_bit_zero, i_clk_sel, i_ch_mode_sel} = '0;
		{i_edge_sel, i_presc_sel, i_wdata, i_cnt_wr, i_cnt_rd_hi} = '0;
		{i_cnt_rd_lo, i_mod_wr_hi, i_mod_wr_lo, i_cv_wr_hi} = '0;
		{i_cv_wr_lo, i_cv_rd_hi, i_cv_rd_lo} = '0;
		tick(8);
		i_sys_rst = 1'b0;
		tick();
		check({o_wrap_flag, o_ch_flag, o_irq, o_ch_oe}, 16'h0, "rst out");
		rd16(1'b1, v);
		check(v, 16'h0000, "reset channel value");
		end_test("reset");
		// Capture channel: value writes dropped, edges per select field.
		i_ch_ie = 1'b1;
		wr16(1'b1, 16'h1234);
		rd16(1'b1, v);
		check(v, 16'h0000, "capture value write");
		for (int s = 0; s < 4; s++)
		begin
			i_edge_sel = s[1:0];
			csc(1'b0);
			for (int e = 0; e < 2; e++)
			begin
				i_ch_pin = !i_ch_pin;
				tick(8);
				exp = (e == 0) ? s[0] : s[1];
				check({15'h0, o_ch_flag}, {15'h0, exp}, "edge flag");
				check({15'h0, o_irq}, {15'h0, exp}, "chan req");
				clr(1'b1, 1'b0);
			end
		end
		end_test("capture");
		// Edge PWM with no clock selected keeps its pin still.
		i_ch_mode_sel = 2'h2;
		i_edge_sel = 2'h2;
		csc(1'b0);
		tick();
		check({15'h0, o_ch_oe}, 16'h0001, "pwm drives pin");
		wr16(1'b0, 16'h0007);
		wr16(1'b1, 16'h0005);
		count_high(20, h);
		check(16'(h), 16'h0000, "frozen edge pwm");
		end_test("frozen");
		// Halted counter reads and counter clear on write.
		i_clk_sel = 2'h1;
		tsc(1'b0);
		tick(5);
		i_dbg_halt = 1'b1;
		tick();
		rd16(1'b0, v);
		rd16(1'b0, w);
		check(w, v, "halted counter read");
		cnt_clr();
		rd16(1'b0, v);
		check(v, 16'h0000, "counter cleared");
		wr16(1'b0, 16'h0003);
		i_dbg_halt = 1'b0;
		end_test("counter");
		// Wrap flag, its request, and the two-step clear.
		clr(1'b0, 1'b1);
		wait_set(1'b0, 20, "edge wrap");
		check({15'h0, o_irq}, 16'h0000, "wrap req disabled");
		i_wrap_ie = 1'b1;
		tsc(1'b0);
		tick();
		check({15'h0, o_irq}, 16'h0001, "wrap req");
		i_dbg_halt = 1'b1;
		wr16(1'b0, 16'h0001);
		cnt_clr();
		i_dbg_halt = 1'b0;
		tick(4);
		clr(1'b0, 1'b0);
		check({15'h0, o_wrap_flag}, 16'h0001, "event mid clear");
		i_dbg_halt = 1'b1;
		tick();
		tsc(1'b1);
		tick(2);
		check({15'h0, o_wrap_flag}, 16'h0001, "zero without read");
		clr(1'b0, 1'b0);
		check({o_wrap_flag, o_irq}, 16'h0000, "flag cleared");
		i_dbg_halt = 1'b0;
		end_test("flags");
		// Center-aligned counting and duty edge cases.
		i_center_sel = 1'b1;
		i_wrap_ie = 1'b0;
		tsc(1'b0);
		wr16(1'b0, 16'h0004);
		cnt_clr();
		clr(1'b0, 1'b1);
		wait_set(1'b0, 20, "center wrap");
		i_ch_mode_sel = 2'h3;
		csc(1'b0);
		for (int i = 0; i < 4; i++)
		begin
			wr16(1'b1, duty_val[i]);
			tick(20);
			count_high(32, h);
			check({15'h0, h >= duty_lo[i] && h <= duty_hi[i]}, 16'h0001,
				"center duty");
		end
		clr(1'b1, 1'b1);
		wait_set(1'b1, 20, "center match");
		end_test("center");
		// Compare buffer waits for a counter step, then matches flag.
		i_center_sel = 1'b0;
		i_presc_sel = 3'h3;
		tsc(1'b0);
		i_ch_mode_sel = 2'h1;
		i_edge_sel = 2'h1;
		csc(1'b0);
		cnt_clr();
		wr16(1'b1, 16'h0003);
		rd16(1'b1, v);
		check(v, 16'h0002, "compare before step");
		tick(12);
		rd16(1'b1, v);
		check(v, 16'h0003, "compare after step");
		clr(1'b1, 1'b1);
		wait_set(1'b1, 100, "compare match");
		i_ch_mode_sel = 2'h2;
		i_edge_sel = 2'h2;
		csc(1'b0);
		clr(1'b1, 1'b1);
		wait_set(1'b1, 100, "edge pwm match");
		end_test("compare");
		test_done();
	end
endmodule : timer_event_flags_and_updates_bench
